// File: dv/tb.sv
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
module tb;
   import tmr16_pkg::*;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   tmr16_io_req_s io_req;
   logic [7:0] io_rdata;
   logic ext_clk = 1'b0;
   logic cap_pin = 1'b0;
   logic comp_out = 1'b0;
   logic cap_comp = 1'b0;
   tmr16_flags_s int_ack = '0;
   tmr16_flags_s irq;
   logic wave_a, wave_b, at_bottom, at_max;
   int n_fail = 0;
   int num_checks = 0;
   logic [7:0] q;
   logic [15:0] v;
   int ns [4] = '{8, 64, 256, 1024};

   always #10 CLK = ~CLK;

   tmr16_core u_dut (.CLK(CLK), .RESET(RESET), .IO_REQ(io_req),
      .IO_RDATA(io_rdata), .EXT_CLK_PIN(ext_clk), .CAPTURE_PIN(cap_pin),
      .COMP_OUT(comp_out), .CAPTURE_FROM_COMP(cap_comp),
      .INT_ACK(int_ack), .IRQ(irq), .WAVE_A(wave_a), .WAVE_B(wave_b),
      .AT_BOTTOM(at_bottom), .AT_MAX(at_max));

   tmr16_host u_host (.CLK(CLK), .RDATA(io_rdata), .REQ(io_req));

   task automatic finish_test;
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic rng(input string nm, input logic [15:0] lo,
                      input logic [15:0] hi, input logic [15:0] got);
      num_checks++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_fail++;
         $display("Error %s expected %h..%h seen %h", nm, lo, hi, got);
      end
   endtask : rng

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] got);
      num_checks++;
      if (got !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, got);
      end
   endtask : chk

   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      u_host.rd(a, q);
      chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
   endtask : rc

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : cyc

   // Pin held 4 cycles each level, well above the sampling limit
   task automatic pulses(input int n);
      repeat (n) begin
         ext_clk = 1'b1;
         cyc(4);
         ext_clk = 1'b0;
         cyc(4);
      end
   endtask : pulses

   initial begin
      #(20 * 90000);
      n_fail++;
      $display("Error watchdog expected finish seen timeout");
      finish_test();
   end

   initial begin
      cyc(10);
      RESET = 1'b0;
      foreach (ns[i]) rc(ADR_SFIO + 6'(i), 8'h00);
      rc(ADR_CTLA, CTL_RST);
      rc(ADR_CTLB, CTL_RST);
      rc(6'h00, 8'h00);
      u_host.wr(ADR_SFIO, 8'hff);
      rc(ADR_SFIO, 8'hee);
      u_host.wr(ADR_SFIO, 8'h00);
      rc(ADR_SFIO, 8'h00);
      u_host.wr(ADR_CTLB, 8'h18);
      u_host.wr(ADR_CTLA, 8'hff);
      rc(ADR_CTLA, 8'hf3);
      rc(ADR_CTLB, 8'h18);
      chk("wave_a", 16'h0, {15'h0, wave_a});
      chk("wave_b", 16'h0, {15'h0, wave_b});
      u_host.wr(ADR_CTLA, 8'h00);
      u_host.wr(ADR_CTLB, 8'h00);
      // Force bit toggles the wave once outside PWM
      u_host.wr(ADR_CTLA, 8'h08);
      chk("force a", 16'h1, {15'h0, wave_a});
      // Byte path through the shared high-byte register
      u_host.wr16(ADR_CNT_H, 16'h1234);
      u_host.rd16(ADR_CNT_L, v);
      chk("cnt", 16'h1234, v);
      u_host.wr(ADR_CNT_H, 8'h56);
      u_host.rd16(ADR_CNT_L, v);
      chk("cnt hi only", 16'h1234, v);
      u_host.wr(ADR_OCA_H, 8'h9a);
      u_host.wr(ADR_CNT_L, 8'h00);
      u_host.rd16(ADR_CNT_L, v);
      chk("shared temp", 16'h9a00, v);
      u_host.wr16(ADR_OCA_H, 16'h2345);
      u_host.wr(ADR_CNT_H, 8'h77);
      u_host.rd16(ADR_OCA_L, v);
      chk("oca", 16'h2345, v);
      rc(ADR_CNT_H, 8'h77);
      // Prescaler taps
      foreach (ns[i]) begin
         u_host.wr(ADR_CTLB, 8'h00);
         u_host.wr16(ADR_CNT_H, 16'h0000);
         u_host.wr(ADR_SFIO, 8'h01);
         u_host.wr(ADR_CTLB, 8'(i + 2));
         cyc(10 * ns[i]);
         u_host.rd16(ADR_CNT_L, v);
         rng("tap", 16'd9, 16'd11, v);
      end
      // External pin, both edges, then stopped
      u_host.wr(ADR_CTLB, 8'h07);
      u_host.wr16(ADR_CNT_H, 16'h0000);
      pulses(5);
      u_host.rd16(ADR_CNT_L, v);
      chk("ext rise", 16'd5, v);
      u_host.wr(ADR_CTLB, 8'h06);
      pulses(1);
      u_host.wr(ADR_CTLB, 8'h00);
      pulses(2);
      u_host.rd16(ADR_CNT_L, v);
      chk("ext fall idle", 16'd6, v);
      // Compare flags and masking
      u_host.wr16(ADR_OCA_H, 16'h0010);
      u_host.wr16(ADR_OCB_H, 16'h0020);
      u_host.wr16(ADR_CNT_H, 16'h000c);
      u_host.wr(ADR_FLAG, 8'h3c);
      u_host.wr(ADR_MASK, 8'h10);
      u_host.wr(ADR_CTLB, 8'h01);
      cyc(40);
      rc(ADR_FLAG, 8'h18);
      chk("irq a b", 16'h2, {14'h0, irq.ocfa, irq.ocfb});
      u_host.wr16(ADR_CNT_H, 16'h1000);
      u_host.rd16(ADR_CNT_L, v);
      rng("cnt write", 16'h1000, 16'h1008, v);
      u_host.wr(ADR_CTLB, 8'h00);
      u_host.wr(ADR_FLAG, 8'h10);
      rc(ADR_FLAG, 8'h08);
      int_ack.ocfb = 1'b1;
      cyc(1);
      int_ack = '0;
      rc(ADR_FLAG, 8'h00);
      // Max and bottom around the wrap
      u_host.wr16(ADR_CNT_H, 16'hfffa);
      u_host.wr(ADR_CTLB, 8'h01);
      for (int k = 0; k < 50 && at_max !== 1'b1; k++) cyc(1);
      if (at_max !== 1'b1) begin
         n_fail++;
         $display("Error at_max expected 1 seen %b", at_max);
      end
      cyc(1);
      chk("bottom", 16'h1, {15'h0, at_bottom});
      u_host.wr(ADR_CTLB, 8'h00);
      rc(ADR_FLAG, 8'h04);
      // Fixed TOP of 0x00ff in fast 8-bit mode
      u_host.wr16(ADR_CNT_H, 16'h00f0);
      u_host.wr(ADR_CTLA, 8'h01);
      u_host.wr(ADR_CTLB, 8'h09);
      cyc(30);
      u_host.wr(ADR_CTLB, 8'h00);
      u_host.rd16(ADR_CNT_L, v);
      rng("top 8", 16'h0000, 16'h0030, v);
      // Phase correct 8-bit turns at TOP and counts down
      u_host.wr16(ADR_CNT_H, 16'h00fe);
      u_host.wr(ADR_CTLB, 8'h01);
      cyc(20);
      u_host.wr(ADR_CTLB, 8'h00);
      u_host.rd16(ADR_CNT_L, v);
      rng("pc down", 16'h00e0, 16'h00f8, v);
      u_host.wr(ADR_CTLA, 8'h00);
      u_host.wr(ADR_FLAG, 8'h3c);
      // Capture from pin then from comparator
      u_host.wr(ADR_MASK, 8'h20);
      u_host.wr16(ADR_CNT_H, 16'h4321);
      u_host.wr(ADR_CTLB, 8'h40);
      cap_pin = 1'b1;
      cyc(10);
      rc(ADR_FLAG, 8'h20);
      chk("irq icf", 16'h1, {15'h0, irq.icf});
      u_host.rd16(ADR_ICR_L, v);
      chk("icr pin", 16'h4321, v);
      int_ack.icf = 1'b1;
      cyc(1);
      int_ack = '0;
      rc(ADR_FLAG, 8'h00);
      cap_comp = 1'b1;
      u_host.wr16(ADR_CNT_H, 16'h0777);
      comp_out = 1'b1;
      cyc(10);
      u_host.rd16(ADR_ICR_L, v);
      chk("icr comp", 16'h0777, v);
      u_host.wr(ADR_FLAG, 8'h20);
      rc(ADR_FLAG, 8'h00);
      finish_test();
   end
endmodule : tb

// File: dv/tmr16_host.sv
// Host CPU model issuing byte accesses on the timer's I/O port
`timescale 1ns/1ps
module tmr16_host
   import tmr16_pkg::*;
(
   input wire logic CLK,
   input wire logic [7:0] RDATA,
   output tmr16_pkg::tmr16_io_req_s REQ
);
   initial REQ = '0;

   // Gap cycle after each access keeps we/re single-cycle pulses
   task automatic acc(input logic [5:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] q);
      @(posedge CLK);
      #1;
      REQ = '{addr: a, wdata: d, we: w, re: !w};
      @(posedge CLK);
      #1;
      REQ = '0;
      q = RDATA;
   endtask : acc

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(a, d, 1'b1, q);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      acc(a, 8'h00, 1'b0, q);
   endtask : rd

   task automatic wr16(input logic [5:0] ah, input logic [15:0] v);
      wr(ah, v[15:8]);
      wr(ah - 6'h01, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [5:0] al, output logic [15:0] v);
      rd(al, v[7:0]);
      rd(al + 6'h01, v[15:8]);
   endtask : rd16
endmodule : tmr16_host

// File: hdl/tmr16_core.sv
// 16-bit timer/counter core with shared high-byte temporary register
// What this block does
// - Prescaler reset bit resets prescaler, self-clears
// - Writing zero ignored; bit reads zero
// - Clock from prescaler or pin; off idles
// - Compare A/B on each counter tick; match sets flag
// - Capture counter on qualified edge, optional filter
// - TOP fixed 0xFF/0x1FF/0x3FF, compare A, capture
// - Compare A as PWM TOP: buffered, no output
// - BOTTOM signalled at counter zero
// - MAX is 0xFFFF regardless of TOP
// - Four flags, individually masked
// - Control registers read/write; force bits read zero
// - Mode split across controls; force bits
// - One shared high-byte temporary register
// - Low write loads temp plus low together
// - Counter or capture low read copies high byte into temp
// - Compare high reads bypass temp
// - Prescaler taps 8/64/256/1024, first count bounded
// - CPU counter write beats count or clear
// - Capture flag set with copy; ack clears
`timescale 1ns/1ps
module tmr16_core
   import tmr16_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire tmr16_pkg::tmr16_io_req_s IO_REQ,
   output logic [7:0] IO_RDATA,
   input wire logic EXT_CLK_PIN,
   input wire logic CAPTURE_PIN,
   input wire logic COMP_OUT,
   input wire logic CAPTURE_FROM_COMP,
   input wire tmr16_pkg::tmr16_flags_s INT_ACK,
   output tmr16_pkg::tmr16_flags_s IRQ,
   output logic WAVE_A,
   output logic WAVE_B,
   output logic AT_BOTTOM,
   output logic AT_MAX
);
   import tmr16_pkg::*;

   typedef struct packed {
      logic [9:0] presc;
      logic psr;
      logic [7:0] sfio;
      logic [7:0] ctla;
      logic [7:0] ctlb;
      logic [15:0] cnt;
      logic [15:0] oca;
      logic [15:0] oca_buf;
      logic [15:0] ocb;
      logic [15:0] ocb_buf;
      logic [15:0] icr;
      logic [7:0] temp;
      tmr16_flags_s flags;
      tmr16_flags_s mask;
      logic dir_up;
      logic ext_s1;
      logic ext_s2;
      logic ext_s3;
      logic cap_s1;
      logic cap_s2;
      logic cmp_s1;
      logic cmp_s2;
      logic [1:0] filt_cnt;
      logic filt_val;
      logic cap_prev;
      logic [7:0] rdata;
      tmr16_flags_s irq;
      logic wave_a;
      logic wave_b;
      logic bottom;
      logic maxed;
   } tmr16_state_s;

   tmr16_state_s st_ff;
   tmr16_state_s nxt_st;

   function automatic logic is_pc(input logic [3:0] m);
      return (m inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
   endfunction : is_pc

   function automatic logic is_fast(input logic [3:0] m);
      return (m inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});
   endfunction : is_fast

   function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] oca,
                                         input logic [15:0] icr);
      case (m)
         4'd1, 4'd5: return TOP_8;
         4'd2, 4'd6: return TOP_9;
         4'd3, 4'd7: return TOP_10;
         4'd4, 4'd9, 4'd11, 4'd15: return oca;
         4'd8, 4'd10, 4'd12, 4'd14: return icr;
         default: return VAL_MAX;
      endcase
   endfunction : top_of

   // Tap fires when the low prescaler bits are all ones
   function automatic logic tap_hit(input logic [9:0] p,
                                    input logic [9:0] msk);
      return ((p & msk) == msk);
   endfunction : tap_hit

   logic [3:0] mode;
   logic [15:0] top;
   assign mode = {st_ff.ctlb[4:3], st_ff.ctla[1:0]};
   assign top = top_of(mode, st_ff.oca, st_ff.icr);

   always_comb begin
      logic tick;
      logic upd;
      logic cap_edge;
      logic cap_in;
      logic hit_a;
      logic hit_b;
      logic wr;
      logic rd;
      logic [5:0] a;
      tmr16_flags_s set_f;
      tmr16_flags_s clr_f;
      tick = 1'b0;
      upd = 1'b0;
      cap_edge = 1'b0;
      cap_in = 1'b0;
      hit_a = 1'b0;
      hit_b = 1'b0;
      wr = IO_REQ.we;
      rd = IO_REQ.re;
      a = IO_REQ.addr;
      set_f = '0;
      clr_f = INT_ACK;
      nxt_st = st_ff;

      // Pin synchronisers; first stages feed only second stages
      nxt_st.ext_s1 = EXT_CLK_PIN;
      nxt_st.ext_s2 = st_ff.ext_s1;
      nxt_st.ext_s3 = st_ff.ext_s2;
      nxt_st.cap_s1 = CAPTURE_PIN;
      nxt_st.cap_s2 = st_ff.cap_s1;
      nxt_st.cmp_s1 = COMP_OUT;
      nxt_st.cmp_s2 = st_ff.cmp_s1;

      // Shared prescaler is free running; reset pulse lasts one cycle
      nxt_st.psr = 1'b0;
      nxt_st.presc = st_ff.psr ? 10'h000 : st_ff.presc + 10'h001;

      case (tmr16_cs_e'(st_ff.ctlb[2:0]))
         TMR16_CS_DIV1: tick = 1'b1;
         TMR16_CS_DIV8: tick = tap_hit(st_ff.presc, PRE_MASK_8);
         TMR16_CS_DIV64: tick = tap_hit(st_ff.presc, PRE_MASK_64);
         TMR16_CS_DIV256: tick = tap_hit(st_ff.presc, PRE_MASK_256);
         TMR16_CS_DIV1024: tick = tap_hit(st_ff.presc, PRE_MASK_1024);
         TMR16_CS_EXT_FALL: tick = st_ff.ext_s3 & ~st_ff.ext_s2;
         TMR16_CS_EXT_RISE: tick = ~st_ff.ext_s3 & st_ff.ext_s2;
         default: tick = 1'b0;
      endcase

      wr = IO_REQ.we;
      // A CPU counter write this cycle cancels the count and the match
      if (wr && (a == ADR_CNT_L)) begin
         tick = 1'b0;
      end

      // Counting sequence
      if (tick) begin
         hit_a = (st_ff.cnt == st_ff.oca);
         hit_b = (st_ff.cnt == st_ff.ocb);
         if (is_pc(mode)) begin
            if (st_ff.dir_up) begin
               if (st_ff.cnt >= top) begin
                  nxt_st.dir_up = 1'b0;
                  nxt_st.cnt = st_ff.cnt - 16'h0001;
                  upd = 1'b1;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 16'h0001;
               end
            end else if (st_ff.cnt == VAL_BOTTOM) begin
               nxt_st.dir_up = 1'b1;
               nxt_st.cnt = st_ff.cnt + 16'h0001;
               set_f.tov = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt - 16'h0001;
            end
         end else if (st_ff.cnt == top) begin
            nxt_st.cnt = VAL_BOTTOM;
            set_f.tov = is_fast(mode) | (st_ff.cnt == VAL_MAX);
            upd = is_fast(mode);
         end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
            set_f.tov = (st_ff.cnt == VAL_MAX);
         end
      end
      if (!is_pc(mode)) begin
         nxt_st.dir_up = 1'b1;
      end
      // Compare values apply at once outside PWM, else at TOP
      if (upd || !(is_pc(mode) || is_fast(mode))) begin
         nxt_st.oca = st_ff.oca_buf;
         nxt_st.ocb = st_ff.ocb_buf;
      end
      set_f.ocfa = hit_a;
      set_f.ocfb = hit_b;

      // Waveform outputs; compare A gives no PWM when it is TOP
      if (is_pc(mode) || is_fast(mode)) begin
         nxt_st.wave_a = (mode != 4'd9) && (mode != 4'd11) &&
                         (mode != 4'd15) && (st_ff.cnt < st_ff.oca);
         nxt_st.wave_b = (st_ff.cnt < st_ff.ocb);
      end else begin
         nxt_st.wave_a = st_ff.wave_a ^ hit_a;
         nxt_st.wave_b = st_ff.wave_b ^ hit_b;
         if (wr && (a == ADR_CTLA)) begin
            nxt_st.wave_a = nxt_st.wave_a ^ IO_REQ.wdata[CTLA_FOCA];
            nxt_st.wave_b = nxt_st.wave_b ^ IO_REQ.wdata[CTLA_FOCB];
         end
      end

      // Capture input: optional four-sample filter then edge select
      // Source picked after syncing, so no raw pin feeds the mux
      cap_in = CAPTURE_FROM_COMP ? st_ff.cmp_s2 : st_ff.cap_s2;
      if (st_ff.ctlb[CTLB_ICNC]) begin
         if (cap_in == st_ff.filt_val) begin
            nxt_st.filt_cnt = 2'h0;
         end else if (st_ff.filt_cnt == FILT_DONE) begin
            nxt_st.filt_cnt = 2'h0;
            nxt_st.filt_val = cap_in;
         end else begin
            nxt_st.filt_cnt = st_ff.filt_cnt + 2'h1;
         end
      end else begin
         nxt_st.filt_cnt = 2'h0;
         nxt_st.filt_val = cap_in;
      end
      nxt_st.cap_prev = st_ff.filt_val;
      cap_edge = (st_ff.filt_val != st_ff.cap_prev) &&
                 (st_ff.filt_val == st_ff.ctlb[CTLB_ICES]);
      // Capture register is TOP in some modes and then not overwritten
      if (cap_edge && !(mode inside {4'd8, 4'd10, 4'd12, 4'd14})) begin
         nxt_st.icr = st_ff.cnt;
         set_f.icf = 1'b1;
      end

      // CPU writes
      if (wr) begin
         if (a == ADR_SFIO) begin
            nxt_st.psr = IO_REQ.wdata[SFIO_PSR];
            nxt_st.sfio = IO_REQ.wdata;
            nxt_st.sfio[SFIO_PSR] = 1'b0;
            nxt_st.sfio[SFIO_GAP] = 1'b0;
         end else if (a == ADR_FLAG) begin
            clr_f = clr_f | tmr16_flags_s'({IO_REQ.wdata[FLG_ICF],
               IO_REQ.wdata[FLG_OCFA], IO_REQ.wdata[FLG_OCFB],
               IO_REQ.wdata[FLG_TOV]});
         end else if (a == ADR_MASK) begin
            nxt_st.mask = tmr16_flags_s'({IO_REQ.wdata[FLG_ICF],
               IO_REQ.wdata[FLG_OCFA], IO_REQ.wdata[FLG_OCFB],
               IO_REQ.wdata[FLG_TOV]});
         end else if (a == ADR_CTLA) begin
            nxt_st.ctla = IO_REQ.wdata;
            nxt_st.ctla[CTLA_FOCA] = 1'b0;
            nxt_st.ctla[CTLA_FOCB] = 1'b0;
         end else if (a == ADR_CTLB) begin
            nxt_st.ctlb = IO_REQ.wdata;
         end else if (a == ADR_CNT_H || a == ADR_OCA_H ||
                      a == ADR_OCB_H || a == ADR_ICR_H) begin
            nxt_st.temp = IO_REQ.wdata;
         end else if (a == ADR_CNT_L) begin
            nxt_st.cnt = {st_ff.temp, IO_REQ.wdata};
         end else if (a == ADR_OCA_L) begin
            nxt_st.oca_buf = {st_ff.temp, IO_REQ.wdata};
         end else if (a == ADR_OCB_L) begin
            nxt_st.ocb_buf = {st_ff.temp, IO_REQ.wdata};
         end else if (a == ADR_ICR_L) begin
            nxt_st.icr = {st_ff.temp, IO_REQ.wdata};
         end
      end

      // CPU reads; data is registered and appears the next cycle
      if (rd) begin
         if (a == ADR_SFIO) begin
            nxt_st.rdata = st_ff.sfio;
         end else if (a == ADR_FLAG) begin
            nxt_st.rdata = {2'b00, st_ff.flags, 2'b00};
         end else if (a == ADR_MASK) begin
            nxt_st.rdata = {2'b00, st_ff.mask, 2'b00};
         end else if (a == ADR_CTLA) begin
            nxt_st.rdata = st_ff.ctla;
         end else if (a == ADR_CTLB) begin
            nxt_st.rdata = st_ff.ctlb;
         end else if (a == ADR_CNT_L) begin
            nxt_st.rdata = st_ff.cnt[7:0];
            nxt_st.temp = st_ff.cnt[15:8];
         end else if (a == ADR_ICR_L) begin
            nxt_st.rdata = st_ff.icr[7:0];
            nxt_st.temp = st_ff.icr[15:8];
         end else if (a == ADR_CNT_H || a == ADR_ICR_H) begin
            nxt_st.rdata = st_ff.temp;
         end else if (a == ADR_OCA_L) begin
            nxt_st.rdata = st_ff.oca_buf[7:0];
         end else if (a == ADR_OCA_H) begin
            nxt_st.rdata = st_ff.oca_buf[15:8];
         end else if (a == ADR_OCB_L) begin
            nxt_st.rdata = st_ff.ocb_buf[7:0];
         end else if (a == ADR_OCB_H) begin
            nxt_st.rdata = st_ff.ocb_buf[15:8];
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end

      // Hardware set wins over acknowledge or write-one clear
      nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;
      nxt_st.irq = st_ff.flags & st_ff.mask;
      nxt_st.bottom = (st_ff.cnt == VAL_BOTTOM);
      nxt_st.maxed = (st_ff.cnt == VAL_MAX);
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_ff <= '0;
         st_ff.sfio <= SFIO_RST;
         st_ff.ctla <= CTL_RST;
         st_ff.ctlb <= CTL_RST;
         st_ff.dir_up <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign IO_RDATA = st_ff.rdata;
   assign IRQ = st_ff.irq;
   assign WAVE_A = st_ff.wave_a;
   assign WAVE_B = st_ff.wave_b;
   assign AT_BOTTOM = st_ff.bottom;
   assign AT_MAX = st_ff.maxed;

   property p_psr_clears;
      @(posedge CLK) disable iff (RESET)
      (IO_REQ.we && IO_REQ.addr == ADR_SFIO && IO_REQ.wdata[SFIO_PSR])
         |=> st_ff.psr ##1 (!st_ff.psr && st_ff.presc == 10'h000);
   endproperty
   a_psr_clears: assert property (p_psr_clears)
      else $error("prescaler reset did not act and self-clear");

   property p_psr_reads_zero;
      @(posedge CLK) disable iff (RESET)
      (IO_REQ.re && IO_REQ.addr == ADR_SFIO) |=> !IO_RDATA[SFIO_PSR];
   endproperty
   a_psr_reads_zero: assert property (p_psr_reads_zero)
      else $error("prescaler reset bit read back as one");

   property p_idle_when_off;
      @(posedge CLK) disable iff (RESET)
      (st_ff.ctlb[2:0] == 3'h0 && !(IO_REQ.we && IO_REQ.addr == ADR_CNT_L))
         |=> $stable(st_ff.cnt);
   endproperty
   a_idle_when_off: assert property (p_idle_when_off)
      else $error("counter moved with no clock source");

   property p_presc_runs;
      @(posedge CLK) disable iff (RESET)
      !st_ff.psr |=> st_ff.presc == $past(st_ff.presc) + 10'h001;
   endproperty
   a_presc_runs: assert property (p_presc_runs)
      else $error("prescaler failed to advance");

   property p_low_write;
      @(posedge CLK) disable iff (RESET)
      (IO_REQ.we && IO_REQ.addr == ADR_CNT_L)
         |=> st_ff.cnt == {$past(st_ff.temp), $past(IO_REQ.wdata)};
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("low write did not load temp and low byte");

   property p_low_read;
      @(posedge CLK) disable iff (RESET)
      (IO_REQ.re && IO_REQ.addr == ADR_CNT_L && !IO_REQ.we)
         |=> st_ff.temp == $past(st_ff.cnt[15:8])
             && IO_RDATA == $past(st_ff.cnt[7:0]);
   endproperty
   a_low_read: assert property (p_low_read)
      else $error("low read did not latch high byte into temp");

   property p_oca_high_read;
      @(posedge CLK) disable iff (RESET)
      (IO_REQ.re && IO_REQ.addr == ADR_OCA_H && !IO_REQ.we)
         |=> IO_RDATA == $past(st_ff.oca_buf[15:8]) && $stable(st_ff.temp);
   endproperty
   a_oca_high_read: assert property (p_oca_high_read)
      else $error("compare high read used temp");

   property p_bottom;
      @(posedge CLK) disable iff (RESET)
      st_ff.cnt == VAL_BOTTOM |=> AT_BOTTOM;
   endproperty
   a_bottom: assert property (p_bottom)
      else $error("BOTTOM not signalled at zero");

   property p_irq_mask;
      @(posedge CLK) disable iff (RESET)
      1'b1 |=> IRQ == ($past(st_ff.flags) & $past(st_ff.mask));
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt request not flags and mask");

   property p_capture;
      @(posedge CLK) disable iff (RESET)
      (st_ff.icr != $past(st_ff.icr)) &&
         !($past(IO_REQ.we) && $past(IO_REQ.addr) == ADR_ICR_L)
         |-> st_ff.flags.icf;
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture copy without capture flag");
endmodule : tmr16_core

// File: hdl/tmr16_pkg.sv
// Constants, field layouts and carrier types for the 16-bit timer core
package tmr16_pkg;
   // I/O register locations on the 8-bit CPU port
   localparam logic [5:0] ADR_SFIO = 6'h30;
   localparam logic [5:0] ADR_FLAG = 6'h38;
   localparam logic [5:0] ADR_MASK = 6'h39;
   localparam logic [5:0] ADR_CTLA = 6'h2f;
   localparam logic [5:0] ADR_CTLB = 6'h2e;
   localparam logic [5:0] ADR_CNT_H = 6'h2d;
   localparam logic [5:0] ADR_CNT_L = 6'h2c;
   localparam logic [5:0] ADR_OCA_H = 6'h2b;
   localparam logic [5:0] ADR_OCA_L = 6'h2a;
   localparam logic [5:0] ADR_OCB_H = 6'h29;
   localparam logic [5:0] ADR_OCB_L = 6'h28;
   localparam logic [5:0] ADR_ICR_H = 6'h27;
   localparam logic [5:0] ADR_ICR_L = 6'h26;
   // Field positions
   localparam int SFIO_PSR = 0;
   localparam int SFIO_GAP = 4;
   localparam int FLG_ICF = 5;
   localparam int FLG_OCFA = 4;
   localparam int FLG_OCFB = 3;
   localparam int FLG_TOV = 2;
   localparam int CTLA_FOCA = 3;
   localparam int CTLA_FOCB = 2;
   localparam int CTLB_ICNC = 7;
   localparam int CTLB_ICES = 6;
   // Reset values and fixed counts
   localparam logic [7:0] SFIO_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [15:0] VAL_BOTTOM = 16'h0000;
   localparam logic [15:0] VAL_MAX = 16'hffff;
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [1:0] FILT_DONE = 2'h3;
   localparam logic [9:0] PRE_MASK_8 = 10'h007;
   localparam logic [9:0] PRE_MASK_64 = 10'h03f;
   localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

   typedef enum logic [2:0] {
      TMR16_CS_OFF, TMR16_CS_DIV1, TMR16_CS_DIV8, TMR16_CS_DIV64,
      TMR16_CS_DIV256, TMR16_CS_DIV1024, TMR16_CS_EXT_FALL,
      TMR16_CS_EXT_RISE
   } tmr16_cs_e;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } tmr16_io_req_s;

   typedef struct packed {
      logic icf;
      logic ocfa;
      logic ocfb;
      logic tov;
   } tmr16_flags_s;
endpackage : tmr16_pkg
